// *** design/iwd_top.sv ***
// word divide unit with quotient and remainder result registers
`timescale 1ns/100ps
`default_nettype none
module iwd_top
  import iwd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic div_valid,
  input wire logic div_signed,
  input wire logic [63:0] dividend_operand,
  input wire logic [63:0] divisor_operand,
  output logic div_ready,
  input wire logic read_quotient_move,
  input wire logic read_remainder_move,
  output logic read_stall,
  output logic read_valid,
  output logic [63:0] read_data,
  output logic [63:0] quotient_result_register,
  output logic [63:0] remainder_result_register,
  output logic improper_word_check,
  output logic arith_exception
);
  typedef struct packed {
    iwd_state_t st;
    logic neg_q;
    logic neg_r;
    logic zero_div;
    logic improper;
    logic [63:0] quo;
    logic [63:0] rem;
    logic [63:0] rd_data;
    logic rd_valid;
  } iwd_top_t;

  iwd_top_t s_q;
  iwd_top_t s_d;
  logic accept;
  logic rd_req;
  logic rd_grant;
  logic core_done;
  logic [31:0] core_quo;
  logic [31:0] core_rem;
  logic [31:0] mag_a;
  logic [31:0] mag_b;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cond_neg(input logic [31:0] x, input logic n);
    cond_neg = n ? (32'h00000000 - x) : x;
  endfunction

  function automatic logic [63:0] sext(input logic [31:0] x);
    sext = {{32{x[IWD_SIGN_BIT]}}, x};
  endfunction

  function automatic logic bad_word(input logic [63:0] x);
    bad_word = !((&x[IWD_CHECK_HI:IWD_CHECK_LO]) || !(|x[IWD_CHECK_HI:IWD_CHECK_LO]));
  endfunction

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // one divide in flight keeps the stall rule trivial
  assign div_ready = (s_q.st == IWD_ST_IDLE);
  assign accept = div_valid && div_ready;
  assign rd_req = read_quotient_move || read_remainder_move;
  assign read_stall = rd_req && (s_q.st != IWD_ST_IDLE);
  assign rd_grant = rd_req && !read_stall;

  // magnitudes feed the unsigned core; unsigned mode passes bits as is
  assign mag_a = cond_neg(dividend_operand[31:0], div_signed && dividend_operand[31]);
  assign mag_b = cond_neg(divisor_operand[31:0], div_signed && divisor_operand[31]);

  iwd_div_core #(
    .W(IWD_WORD_W)
  ) u_core (
    .clk(clk),
    .rst_n(rst_n),
    .start(accept),
    .dividend(mag_a),
    .divisor(mag_b),
    .done(core_done),
    .quotient(core_quo),
    .remainder(core_rem)
  );

  // ----------------------------------------------------------------
  // sequencer and result registers
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    // read samples the old value before any later write-back
    if (rd_grant)
    begin
      s_d.rd_data = read_quotient_move ? s_q.quo : s_q.rem;
      s_d.rd_valid = 1'b1;
    end
    case (s_q.st)
      IWD_ST_IDLE:
      begin
        if (accept)
        begin
          s_d.st = IWD_ST_RUN;
          s_d.neg_q = div_signed && (dividend_operand[31] ^ divisor_operand[31]);
          s_d.neg_r = div_signed && dividend_operand[31];
          s_d.zero_div = (divisor_operand[31:0] == IWD_WORD_ZERO);
          s_d.improper = bad_word(dividend_operand) || bad_word(divisor_operand);
        end
      end
      IWD_ST_RUN:
      begin
        if (core_done)
        begin
          s_d.st = IWD_ST_IDLE;
          if (s_q.zero_div)
          begin
            s_d.quo = IWD_ZERO_DIV_QUO;
            s_d.rem = IWD_ZERO_DIV_REM;
          end
          else
          begin
            s_d.quo = sext(cond_neg(core_quo, s_q.neg_q));
            s_d.rem = sext(cond_neg(core_rem, s_q.neg_r));
          end
        end
      end
      default:
      begin
        s_d.st = IWD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q.st <= IWD_ST_IDLE;
      s_q.neg_q <= 1'b0;
      s_q.neg_r <= 1'b0;
      s_q.zero_div <= 1'b0;
      s_q.improper <= 1'b0;
      s_q.quo <= IWD_RESULT_RST;
      s_q.rem <= IWD_RESULT_RST;
      s_q.rd_data <= IWD_RESULT_RST;
      s_q.rd_valid <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign quotient_result_register = s_q.quo;
  assign remainder_result_register = s_q.rem;
  assign read_data = s_q.rd_data;
  assign read_valid = s_q.rd_valid;
  assign improper_word_check = s_q.improper;
  // overflow and zero divisor are software's to check
  assign arith_exception = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [31:0] h_a;
  logic [31:0] h_b;
  logic h_s;
  logic [5:0] h_run_cnt;

  // cycles spent running; a long divide is checked on a counter, not unrolled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      h_run_cnt <= 6'h00;
    else if (s_q.st == IWD_ST_RUN)
      h_run_cnt <= h_run_cnt + 6'h01;
    else
      h_run_cnt <= 6'h00;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      h_a <= IWD_WORD_ZERO;
      h_b <= IWD_WORD_ZERO;
      h_s <= 1'b0;
    end
    else if (accept)
    begin
      h_a <= dividend_operand[31:0];
      h_b <= divisor_operand[31:0];
      h_s <= div_signed;
    end
  end

  function automatic logic [63:0] ref_q(input logic [31:0] a, input logic [31:0] b,
                                       input logic s);
    ref_q = s ? sext(32'($signed(a) / $signed(b))) : sext(a / b);
  endfunction

  function automatic logic [63:0] ref_r(input logic [31:0] a, input logic [31:0] b,
                                       input logic s);
    ref_r = s ? sext(32'($signed(a) % $signed(b))) : sext(a % b);
  endfunction

  logic h_ok;
  assign h_ok = (h_b != IWD_WORD_ZERO) && !(h_s && (h_a == 32'h80000000) && (&h_b));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_signed_quo;
    (s_q.st == IWD_ST_RUN) && core_done && h_s && h_ok |=> s_q.quo == ref_q(h_a, h_b, 1'b1);
  endproperty
  a_signed_quo: assert property (p_signed_quo) else $error("signed quotient wrong");

  property p_rem_sext;
    (s_q.st == IWD_ST_RUN) && core_done && h_ok |=> s_q.rem == ref_r(h_a, h_b, h_s);
  endproperty
  a_rem_sext: assert property (p_rem_sext) else $error("remainder wrong");

  property p_unsigned_quo;
    (s_q.st == IWD_ST_RUN) && core_done && !h_s && h_ok |=> s_q.quo == ref_q(h_a, h_b, 1'b0);
  endproperty
  a_unsigned_quo: assert property (p_unsigned_quo) else $error("unsigned quotient wrong");

  property p_no_exc;
    accept |-> !arith_exception [*8];
  endproperty
  a_no_exc: assert property (p_no_exc) else $error("exception raised");

  property p_improper;
    accept && (bad_word(dividend_operand) || bad_word(divisor_operand)) |=> improper_word_check;
  endproperty
  a_improper: assert property (p_improper) else $error("improper word not flagged");

  property p_latency;
    (s_q.st == IWD_ST_RUN) |-> (core_done == (h_run_cnt == 6'(IWD_DIV_STEPS)));
  endproperty
  a_latency: assert property (p_latency) else $error("divide latency wrong");

  property p_stable;
    (s_q.st == IWD_ST_RUN) && !core_done |=> $stable(quotient_result_register);
  endproperty
  a_stable: assert property (p_stable) else $error("result changed early");

  property p_stall;
    (s_q.st == IWD_ST_RUN) && rd_req |-> read_stall ##1 !read_valid;
  endproperty
  a_stall: assert property (p_stall) else $error("read not stalled");

  property p_read_old;
    rd_grant && read_quotient_move |=> read_valid && (read_data == $past(s_q.quo));
  endproperty
  a_read_old: assert property (p_read_old) else $error("read corrupted");

  property p_zero_div;
    accept && (divisor_operand[31:0] == IWD_WORD_ZERO) |-> ##34
      (quotient_result_register == IWD_ZERO_DIV_QUO) &&
      (remainder_result_register == IWD_ZERO_DIV_REM);
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("zero divisor pattern wrong");
endmodule
`default_nettype wire

// *** design/iwd_pkg.sv ***
// constants and types shared by the word divider files
`default_nettype none
package iwd_pkg;
  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned IWD_WORD_W = 32;
  localparam int unsigned IWD_DWORD_W = 64;
  localparam int unsigned IWD_DIV_STEPS = 32;
  // accept cycle, one cycle per quotient bit, one write-back cycle
  localparam int unsigned IWD_DIV_LATENCY = IWD_DIV_STEPS + 2;
  localparam int unsigned IWD_SIGN_BIT = 31;
  localparam int unsigned IWD_CHECK_LO = 31;
  localparam int unsigned IWD_CHECK_HI = 63;

  // ----------------------------------------------------------------
  // result values
  // ----------------------------------------------------------------
  localparam logic [63:0] IWD_RESULT_RST = 64'h0000000000000000;
  localparam logic [63:0] IWD_ZERO_DIV_QUO = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [63:0] IWD_ZERO_DIV_REM = 64'h0000000000000000;
  localparam logic [31:0] IWD_WORD_ZERO = 32'h00000000;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    IWD_ST_IDLE = 1'b0,
    IWD_ST_RUN = 1'b1
  } iwd_state_t;
endpackage
`default_nettype wire

// *** design/iwd_div_core.sv ***
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module iwd_div_core
  import iwd_pkg::*;
#(
  parameter int unsigned W = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic done,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder
);
  localparam int unsigned CW = $clog2(W) + 1;
  localparam logic [CW-1:0] CNT_LOAD = CW'(W);
  localparam logic [CW-1:0] CNT_LAST = CW'(1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [W-1:0] quo;
    logic [W-1:0] rem;
    logic [W-1:0] dvs;
  } iwd_core_t;

  iwd_core_t s_q;
  iwd_core_t s_d;

  // ----------------------------------------------------------------
  // step logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [W:0] shifted;
    logic [W:0] diff;
    shifted = {s_q.rem, s_q.quo[W-1]};
    diff = shifted - {1'b0, s_q.dvs};
    s_d = s_q;
    s_d.done = 1'b0;
    if (start)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = CNT_LOAD;
      s_d.quo = dividend;
      s_d.rem = '0;
      s_d.dvs = divisor;
    end
    else if (s_q.busy)
    begin
      // a zero divisor still steps through every bit, never a hang
      if (!diff[W])
      begin
        s_d.rem = diff[W-1:0];
        s_d.quo = {s_q.quo[W-2:0], 1'b1};
      end
      else
      begin
        s_d.rem = shifted[W-1:0];
        s_d.quo = {s_q.quo[W-2:0], 1'b0};
      end
      s_d.cnt = s_q.cnt - CNT_LAST;
      if (s_q.cnt == CNT_LAST)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;
  assign quotient = s_q.quo;
  assign remainder = s_q.rem;
endmodule
`default_nettype wire

// *** verif/iwd_pipe_model.sv ***
// pipeline model issuing word divides and result reads
`timescale 1ns/100ps
`default_nettype none
module iwd_pipe_model
  import iwd_pkg::*;
(
  input wire logic clk,
  input wire logic div_ready,
  input wire logic read_stall,
  input wire logic read_valid,
  input wire logic [63:0] read_data,
  output var logic div_valid,
  output var logic div_signed,
  output var logic [63:0] dividend_operand,
  output var logic [63:0] divisor_operand,
  output var logic read_quotient_move,
  output var logic read_remainder_move
);
  initial
  begin
    div_valid = 1'b0;
    div_signed = 1'b0;
    dividend_operand = 64'h0;
    divisor_operand = 64'h0;
    read_quotient_move = 1'b0;
    read_remainder_move = 1'b0;
  end

  // request held until accepted; bounded so a lost handshake shows up
  task automatic do_div(input logic sgn, input logic [63:0] a, input logic [63:0] b);
    int n;
    n = 0;
    @(posedge clk);
    div_valid <= 1'b1;
    div_signed <= sgn;
    dividend_operand <= a;
    divisor_operand <= b;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (div_ready !== 1'b1 && n < 100);
    div_valid <= 1'b0;
    div_signed <= ~sgn;
    // released operands must not look still valid
    dividend_operand <= ~a;
    divisor_operand <= ~b;
  endtask

  task automatic do_read(input logic rem, output logic [63:0] data, output logic stalled,
                         output logic vld);
    int n;
    n = 0;
    stalled = 1'b0;
    @(posedge clk);
    read_quotient_move <= ~rem;
    read_remainder_move <= rem;
    do
    begin
      @(posedge clk);
      n++;
      if (read_stall === 1'b1) stalled = 1'b1;
    end
    while (read_stall !== 1'b0 && n < 100);
    read_quotient_move <= 1'b0;
    read_remainder_move <= 1'b0;
    #1;
    vld = read_valid;
    data = read_data;
  endtask
endmodule
`default_nettype wire

// *** verif/test_integer_word_divider.sv ***
// self-checking bench for the word divide unit
`timescale 1ns/100ps
`default_nettype none
module test_integer_word_divider
  import iwd_pkg::*;
;
  logic clk;
  logic rst_n;
  wire logic div_valid;
  wire logic div_signed;
  wire logic [63:0] dividend_operand;
  wire logic [63:0] divisor_operand;
  wire logic read_quotient_move;
  wire logic read_remainder_move;
  logic div_ready;
  logic read_stall;
  logic read_valid;
  logic [63:0] read_data;
  logic [63:0] quo;
  logic [63:0] rem;
  logic improper;
  logic exc;
  int errors;
  int check_count;

  iwd_top DUT (.clk(clk), .rst_n(rst_n), .div_valid(div_valid), .div_signed(div_signed),
    .dividend_operand(dividend_operand), .divisor_operand(divisor_operand),
    .div_ready(div_ready), .read_quotient_move(read_quotient_move),
    .read_remainder_move(read_remainder_move), .read_stall(read_stall),
    .read_valid(read_valid), .read_data(read_data), .quotient_result_register(quo),
    .remainder_result_register(rem), .improper_word_check(improper), .arith_exception(exc));

  iwd_pipe_model u_pipe (.clk(clk), .div_ready(div_ready), .read_stall(read_stall),
    .read_valid(read_valid), .read_data(read_data), .div_valid(div_valid),
    .div_signed(div_signed), .dividend_operand(dividend_operand),
    .divisor_operand(divisor_operand), .read_quotient_move(read_quotient_move),
    .read_remainder_move(read_remainder_move));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [63:0] sx(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction

  task automatic run_div(input logic sgn, input logic [63:0] a, input logic [63:0] b,
                         input logic bad);
    logic [31:0] q32;
    logic [31:0] r32;
    logic [63:0] q_old;
    longint sa;
    longint sb;
    sa = $signed(a[31:0]);
    sb = $signed(b[31:0]);
    q32 = sgn ? 32'(sa / sb) : a[31:0] / b[31:0];
    r32 = sgn ? 32'(sa % sb) : a[31:0] % b[31:0];
    u_pipe.do_div(sgn, a, b);
    q_old = quo;
    repeat (32) @(posedge clk);
    #1;
    check(64'(div_ready), 64'h0);
    check(quo, q_old);
    @(posedge clk);
    #1;
    check(64'(div_ready), 64'h1);
    check(quo, b[31:0] == 32'h0 ? IWD_ZERO_DIV_QUO : sx(q32));
    check(rem, b[31:0] == 32'h0 ? IWD_ZERO_DIV_REM : sx(r32));
    check(64'(improper), 64'(bad));
    check(64'(exc), 64'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_signed();
    run_div(1'b1, sx(32'h00000064), sx(32'h00000007), 1'b0);
    run_div(1'b1, sx(32'hFFFFFF9C), sx(32'h00000007), 1'b0);
    run_div(1'b1, sx(32'h00000064), sx(32'hFFFFFFF9), 1'b0);
    run_div(1'b1, sx(32'h80000000), sx(32'hFFFFFFFF), 1'b0);
  endtask

  task automatic t_unsigned();
    run_div(1'b0, sx(32'hFFFFFFFF), sx(32'h00000002), 1'b0);
    run_div(1'b0, sx(32'hFFFFFFF0), sx(32'h00000001), 1'b0);
    run_div(1'b0, sx(32'h80000005), sx(32'h80000000), 1'b0);
  endtask

  task automatic t_zero_and_improper();
    run_div(1'b1, sx(32'h00000064), 64'h0, 1'b0);
    run_div(1'b0, sx(32'hFFFFFFFF), 64'h0, 1'b0);
    run_div(1'b0, 64'h0000000080000000, sx(32'h00000003), 1'b1);
    run_div(1'b1, sx(32'h00000009), 64'h1234567800000005, 1'b1);
  endtask

  // read raised while the divide runs must wait for the new result
  task automatic t_stall();
    logic [63:0] d;
    logic st;
    logic v;
    u_pipe.do_div(1'b0, sx(32'h000003E8), sx(32'h00000003));
    u_pipe.do_read(1'b0, d, st, v);
    check(64'(st), 64'h1);
    check(64'(v), 64'h1);
    check(d, 64'h14D);
    u_pipe.do_read(1'b1, d, st, v);
    check(d, 64'h1);
  endtask

  // read granted at the accept edge keeps the old value
  task automatic t_read_then_div();
    logic [63:0] d;
    logic st;
    logic v;
    fork
      u_pipe.do_div(1'b0, sx(32'h00000064), sx(32'h00000009));
      u_pipe.do_read(1'b0, d, st, v);
    join
    check(64'(st), 64'h0);
    check(d, 64'h14D);
    u_pipe.do_read(1'b0, d, st, v);
    check(d, 64'hB);
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;

  initial
  begin
    errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(64'(div_ready), 64'h1);
    check(quo, IWD_RESULT_RST);
    check(rem, IWD_RESULT_RST);
    check(64'(read_valid), 64'h0);
    t_signed();
    t_unsigned();
    t_zero_and_improper();
    t_stall();
    t_read_then_div();
    give_verdict();
  end

  // whole run is well under a thousand cycles
  initial
  begin
    #500000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
